// [src/wss_pkg.sv]
// Package of addresses, bit positions and reset values for the wake and switch status bank.
package wss_pkg;

    //////////////////////////////////////////////////////////////////////////////////////////
    // Register addresses on the 7-bit control interface address field.
    localparam logic [6:0] ADDR_WAKE_MAIN = 7'h46;  // Bus, timer and wake-input wake flags.
    localparam logic [6:0] ADDR_WAKE_GP   = 7'h47;  // General-purpose pin wake flags.
    localparam logic [6:0] ADDR_LEVEL     = 7'h48;  // Live or sampled input levels.
    localparam logic [6:0] ADDR_OVERLOAD  = 7'h54;  // High-side over-current or over-temperature.
    localparam logic [6:0] ADDR_OPEN_LOAD = 7'h55;  // High-side open-load flags.

    //////////////////////////////////////////////////////////////////////////////////////////
    // Bit positions inside the wake source register.
    localparam int BIT_LIN_WAKE   = 6;  // LIN bus wake flag.
    localparam int BIT_CAN_WAKE   = 5;  // CAN bus wake flag.
    localparam int BIT_TIMER_WAKE = 4;  // Internal timer wake flag.
    localparam int BIT_WK_LSB     = 0;  // Wake inputs one to three occupy bits 0 to 2.

    // Bit positions inside the general-purpose wake register and the level register.
    localparam int BIT_GP_LSB     = 4;  // General-purpose pins one and two occupy bits 4 and 5.
    localparam int BIT_STRAP      = 7;  // Development strap level on the test pin.
    localparam int BIT_PULLUP     = 6;  // External pull-up detected on the interrupt pin.

    // Bit position of the four high-side switch flags.
    localparam int BIT_HS_LSB     = 0;  // Switches one to four occupy bits 0 to 3.

    //////////////////////////////////////////////////////////////////////////////////////////
    // Counts and reset values.
    localparam int         NUM_WK     = 3;      // Number of high-voltage wake inputs.
    localparam int         NUM_GP     = 2;      // Number of general-purpose pins.
    localparam int         NUM_HS     = 4;      // Number of high-side switches.
    localparam logic [7:0] RST_BYTE   = 8'h00;  // Power-on and soft reset value of every flag.
    localparam logic [7:0] READ_NONE  = 8'h00;  // Answer to an unmapped address.

endpackage

// [src/wss_lvl_if.sv]
// Interface that carries synchronised pin levels from the sampler to the register bank.
`timescale 1ns/100ps
interface wss_lvl_if;
    logic [wss_pkg::NUM_WK-1:0] wk_lvl;     // Synchronised wake input levels.
    logic [wss_pkg::NUM_GP-1:0] gp_lvl;     // Synchronised general-purpose pin levels.
    logic                       strap_lvl;  // Synchronised development strap level.
    logic                       pullup_lvl; // Synchronised interrupt pull-up detect level.

    // The sampler drives the levels.
    modport src (output wk_lvl, output gp_lvl, output strap_lvl, output pullup_lvl);
    // The register bank reads them.
    modport dst (input wk_lvl, input gp_lvl, input strap_lvl, input pullup_lvl);
endinterface

// [src/wss_pin_sync.sv]
// Two-flop synchroniser for the asynchronous pin levels read by the status bank.
`timescale 1ns/100ps
module wss_pin_sync #(
    parameter int NUM_WK = wss_pkg::NUM_WK,
    parameter int NUM_GP = wss_pkg::NUM_GP
) (
    // Clock and reset.
    input  wire logic              i_clk,
    input  wire logic              i_srst,
    // Asynchronous pins.
    input  wire logic [NUM_WK-1:0] i_wk_pin,
    input  wire logic [NUM_GP-1:0] i_gp_pin,
    input  wire logic              i_strap_pin,
    input  wire logic              i_pullup_pin,
    // Synchronised levels.
    wss_lvl_if.src                 lvl
);

    localparam int W = NUM_WK + NUM_GP + 2;  // Total number of synchronised pins.

    // All state of the sampler: first and second synchroniser stages.
    typedef struct packed {
        logic [W-1:0] meta;   // First stage, read only by the second stage.
        logic [W-1:0] sync;   // Second stage, safe for logic.
    } wss_sync_state_t;

    wss_sync_state_t sync_reg;   // Registered state.
    wss_sync_state_t sync_next;  // Next state.

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Next state: shift every pin through the two stages.
    always_comb begin
        sync_next      = sync_reg;
        sync_next.meta = {i_pullup_pin, i_strap_pin, i_gp_pin, i_wk_pin};
        sync_next.sync = sync_reg.meta;
    end

    // Register the state; reset parks both stages low.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Only the second stage leaves the module.
    assign lvl.wk_lvl     = sync_reg.sync[NUM_WK-1:0];
    assign lvl.gp_lvl     = sync_reg.sync[NUM_WK+NUM_GP-1:NUM_WK];
    assign lvl.strap_lvl  = sync_reg.sync[W-2];
    assign lvl.pullup_lvl = sync_reg.sync[W-1];

endmodule

// [src/wss_status_regs.sv]
// Wake source, input level and high-side switch status registers with host clear commands.
// What this block does
// - LIN, CAN, timer wakes set bits 6,5,4.
// - Reserved bits always read zero.
// - Fail-safe exit wakes also set flags.
// - Level bit 7 shows development strap.
// - Level bit 6 shows interrupt pull-up.
// - Level bits 5,4 show general-purpose pins.
// - Refresh pin levels in normal/stop when configured.
// - Cyclic mode: wake levels update per sample.
// - General-purpose pins never cyclically sampled.
// - Selected pin shows level despite switch use.
// - Overload bits 3..0 flag switches four..one.
// - Overload flags may be spurious at low supply.
// - Flags never self-clear; only host clear or reset clears.
`timescale 1ns/100ps
module wss_status_regs #(
    parameter int NUM_WK = wss_pkg::NUM_WK,
    parameter int NUM_GP = wss_pkg::NUM_GP,
    parameter int NUM_HS = wss_pkg::NUM_HS
) (
    // Clock and reset.
    input  wire logic              i_clk,
    input  wire logic              i_srst,
    // Wake event pulses from the wake state machine.
    input  wire logic              i_lin_wake_evt,
    input  wire logic              i_can_wake_evt,
    input  wire logic              i_timer_wake_evt,
    input  wire logic [NUM_WK-1:0] i_wk_wake_evt,
    input  wire logic [NUM_GP-1:0] i_gp_wake_evt,
    // Switch diagnosis events from the high-side sensing logic.
    input  wire logic [NUM_HS-1:0] i_hs_overload_evt,
    input  wire logic [NUM_HS-1:0] i_hs_open_load_evt,
    // Operating state and pin configuration.
    input  wire logic              i_normal_or_stop,
    input  wire logic              i_cyclic_active,
    input  wire logic              i_cyclic_sample,
    input  wire logic [NUM_GP-1:0] i_gp_sel_gpio,
    input  wire logic [NUM_GP-1:0] i_gp_cfg_active,
    // Asynchronous pins.
    input  wire logic [NUM_WK-1:0] i_wk_pin,
    input  wire logic [NUM_GP-1:0] i_gp_pin,
    input  wire logic              i_fail_out_test_pin,
    input  wire logic              i_int_pullup_pin,
    // Register access from the serial control interface decoder.
    input  wire logic [6:0]        i_reg_addr,
    input  wire logic              i_reg_rd,
    input  wire logic              i_reg_clr,
    output logic [7:0]             o_reg_rdata,
    output logic                   o_reg_rvalid
);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // All state of the bank in one packed struct.
    typedef struct packed {
        logic              lin_bus_wake_flag;    // LIN bus woke the device.
        logic              can_bus_wake_flag;    // CAN bus woke the device.
        logic              timer_wake_flag;      // Internal timer woke the device.
        logic [NUM_WK-1:0] wk_wake_flag;         // Wake inputs one to three.
        logic [NUM_GP-1:0] gp_wake_flag;         // General-purpose pins one and two.
        logic [NUM_WK-1:0] wk_level;             // Held wake input levels.
        logic [NUM_GP-1:0] gp_level;             // Held general-purpose pin levels.
        logic [NUM_HS-1:0] overload_flag;        // Over-current or over-temperature.
        logic [NUM_HS-1:0] open_load_flag;       // Open load.
        logic [7:0]        rdata;                // Read answer.
        logic              rvalid;               // Read answer strobe.
    } wss_bank_state_t;

    wss_bank_state_t bank_reg;   // Registered state.
    wss_bank_state_t bank_next;  // Next state.

    wss_lvl_if lvl ();           // Synchronised pin levels.

    // Synchroniser for every pin that the bank reports.
    wss_pin_sync #(
        .NUM_WK (NUM_WK),
        .NUM_GP (NUM_GP)
    ) u_sync (
        .i_clk        (i_clk),
        .i_srst       (i_srst),
        .i_wk_pin     (i_wk_pin),
        .i_gp_pin     (i_gp_pin),
        .i_strap_pin  (i_fail_out_test_pin),
        .i_pullup_pin (i_int_pullup_pin),
        .lvl          (lvl)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Sticky flag update: a new event wins over a clear in the same cycle, so nothing is lost.
    function automatic logic sticky(input logic cur, input logic set, input logic clr);
        sticky = set | (cur & ~clr);
    endfunction

    // Vector form of the same update for the multi-bit flag groups.
    function automatic logic [7:0] sticky_vec(input logic [7:0] cur, input logic [7:0] set,
                                              input logic clr);
        sticky_vec = set | (cur & ~{8{clr}});
    endfunction

    // Clear strobes per register, decoded once.
    logic clr_main;   // Clear command to the wake source register.
    logic clr_gp;     // Clear command to the general-purpose wake register.
    logic clr_ovl;    // Clear command to the overload register.
    logic clr_ol;     // Clear command to the open-load register.
    logic [7:0] sv_wk;   // Scratch for the wake input flags.
    logic [7:0] sv_gp;   // Scratch for the general-purpose wake flags.
    logic [7:0] sv_ovl;  // Scratch for the overload flags.
    logic [7:0] sv_ol;   // Scratch for the open-load flags.

    // A clear to the level register is a clear of read-only bits and is simply ignored.
    assign clr_main = i_reg_clr && (i_reg_addr == wss_pkg::ADDR_WAKE_MAIN);
    assign clr_gp   = i_reg_clr && (i_reg_addr == wss_pkg::ADDR_WAKE_GP);
    assign clr_ovl  = i_reg_clr && (i_reg_addr == wss_pkg::ADDR_OVERLOAD);
    assign clr_ol   = i_reg_clr && (i_reg_addr == wss_pkg::ADDR_OPEN_LOAD);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Next state of flags, levels and the read answer.
    always_comb begin
        bank_next = bank_reg;
        sv_wk     = 8'h00;
        sv_gp     = 8'h00;
        sv_ovl    = 8'h00;
        sv_ol     = 8'h00;

        // Wake flags set on any wake, including one that ends fail-safe; no self-clear.
        bank_next.lin_bus_wake_flag = sticky(bank_reg.lin_bus_wake_flag, i_lin_wake_evt,
                                             clr_main);
        bank_next.can_bus_wake_flag = sticky(bank_reg.can_bus_wake_flag, i_can_wake_evt,
                                             clr_main);
        bank_next.timer_wake_flag   = sticky(bank_reg.timer_wake_flag, i_timer_wake_evt,
                                             clr_main);
        sv_wk = sticky_vec(8'(bank_reg.wk_wake_flag), 8'(i_wk_wake_evt), clr_main);
        bank_next.wk_wake_flag = sv_wk[NUM_WK-1:0];
        sv_gp = sticky_vec(8'(bank_reg.gp_wake_flag), 8'(i_gp_wake_evt), clr_gp);
        bank_next.gp_wake_flag = sv_gp[NUM_GP-1:0];

        // Switch flags; overload may be set spuriously at low supply, software must judge.
        sv_ovl = sticky_vec(8'(bank_reg.overload_flag), 8'(i_hs_overload_evt), clr_ovl);
        bank_next.overload_flag = sv_ovl[NUM_HS-1:0];
        sv_ol = sticky_vec(8'(bank_reg.open_load_flag), 8'(i_hs_open_load_evt), clr_ol);
        bank_next.open_load_flag = sv_ol[NUM_HS-1:0];

        // Wake input levels: follow the pin, or only the last sample in cyclic operation.
        if (i_cyclic_active) begin
            if (i_cyclic_sample) begin
                bank_next.wk_level = lvl.wk_lvl;
            end
        end else begin
            bank_next.wk_level = lvl.wk_lvl;
        end

        // General-purpose levels: refreshed per pin, never by the cyclic sample strobe.
        for (int g = 0; g < NUM_GP; g++) begin
            if (i_normal_or_stop && (i_gp_sel_gpio[g] || i_gp_cfg_active[g])) begin
                bank_next.gp_level[g] = lvl.gp_lvl[g];
            end
        end

        // Read answer; unspecified bits stay zero so reserved positions read as zero.
        bank_next.rvalid = i_reg_rd;
        bank_next.rdata  = wss_pkg::READ_NONE;
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                wss_pkg::ADDR_WAKE_MAIN: begin
                    bank_next.rdata[wss_pkg::BIT_LIN_WAKE]   = bank_reg.lin_bus_wake_flag;
                    bank_next.rdata[wss_pkg::BIT_CAN_WAKE]   = bank_reg.can_bus_wake_flag;
                    bank_next.rdata[wss_pkg::BIT_TIMER_WAKE] = bank_reg.timer_wake_flag;
                    bank_next.rdata[wss_pkg::BIT_WK_LSB +: NUM_WK] = bank_reg.wk_wake_flag;
                end
                wss_pkg::ADDR_WAKE_GP: begin
                    bank_next.rdata[wss_pkg::BIT_GP_LSB +: NUM_GP] = bank_reg.gp_wake_flag;
                end
                wss_pkg::ADDR_LEVEL: begin
                    bank_next.rdata[wss_pkg::BIT_STRAP]  = lvl.strap_lvl;
                    bank_next.rdata[wss_pkg::BIT_PULLUP] = lvl.pullup_lvl;
                    bank_next.rdata[wss_pkg::BIT_GP_LSB +: NUM_GP] = bank_reg.gp_level;
                    bank_next.rdata[wss_pkg::BIT_WK_LSB +: NUM_WK] = bank_reg.wk_level;
                end
                wss_pkg::ADDR_OVERLOAD: begin
                    bank_next.rdata[wss_pkg::BIT_HS_LSB +: NUM_HS] = bank_reg.overload_flag;
                end
                wss_pkg::ADDR_OPEN_LOAD: begin
                    bank_next.rdata[wss_pkg::BIT_HS_LSB +: NUM_HS] =
                        bank_reg.open_load_flag;
                end
                default: begin
                    // Unmapped address: the answer stays zero.
                    bank_next.rdata = wss_pkg::READ_NONE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Register the state. Of the resets, only power-on or soft reset clears the flags; a restart of the
    // device is not a reset of this bank, so the flags survive it.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            bank_reg <= '0;
        end else begin
            bank_reg <= bank_next;
        end
    end

    // Outputs come straight from the registered state.
    assign o_reg_rdata  = bank_reg.rdata;
    assign o_reg_rvalid = bank_reg.rvalid;

endmodule

// [dv/wss_status_regs_assertions.sv]
// Checker of the wake and switch status bank, bound to its top module.
`timescale 1ns/100ps
module wss_status_regs_assertions #(
    parameter int NUM_HS = wss_pkg::NUM_HS
) (
    input wire logic              i_clk,
    input wire logic              i_srst,
    input wire logic              i_lin_wake_evt,
    input wire logic              i_can_wake_evt,
    input wire logic [NUM_HS-1:0] i_hs_overload_evt,
    input wire logic              i_fail_out_test_pin,
    input wire logic [6:0]        i_reg_addr,
    input wire logic              i_reg_rd,
    input wire logic              i_reg_clr,
    input wire logic [7:0]        o_reg_rdata,
    input wire logic              o_reg_rvalid
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    logic ovl_seen; // Expected state of the switch one overload flag.
    ////////////////////////////////////////////////////////////////////////////////////
    // Events set the flag; reset, or a clear with no event in the same cycle, drops it.
    always_ff @(posedge i_clk) begin
        if (i_srst || (i_reg_clr && i_reg_addr == wss_pkg::ADDR_OVERLOAD)) begin
            ovl_seen <= i_hs_overload_evt[0] && !i_srst;
        end else if (i_hs_overload_evt[0]) begin
            ovl_seen <= 1'b1;
        end
    end
    // Reserved bits of each address; unmapped addresses read wholly zero.
    function automatic logic [7:0] rsv(input logic [6:0] a);
        case (a)
            wss_pkg::ADDR_WAKE_MAIN: return 8'h88;
            wss_pkg::ADDR_WAKE_GP:   return 8'hcf;
            wss_pkg::ADDR_LEVEL:     return 8'h08;
            wss_pkg::ADDR_OVERLOAD:  return 8'hf0;
            wss_pkg::ADDR_OPEN_LOAD: return 8'hf0;
            default:                 return 8'hff;
        endcase
    endfunction
    sequence rd_of(logic [6:0] a);
        i_reg_rd && i_reg_addr == a;
    endsequence
    AST_RD_ANSWER: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read got no answer");
    AST_NO_STRAY: assert property (!i_reg_rd |=> !o_reg_rvalid)
        else $error("answer without read");
    AST_IDLE_ZERO: assert property (!o_reg_rvalid |-> o_reg_rdata == 8'h00)
        else $error("read data not zero when idle");
    AST_RESERVED: assert property (
        o_reg_rvalid |-> (o_reg_rdata & rsv($past(i_reg_addr))) == 8'h00)
        else $error("reserved bit read as one");
    AST_CAN_SET: assert property (
        i_can_wake_evt ##1 rd_of(wss_pkg::ADDR_WAKE_MAIN) |=> o_reg_rdata[5])
        else $error("bus wake flag not set");
    AST_LIN_SET: assert property (
        i_lin_wake_evt ##1 rd_of(wss_pkg::ADDR_WAKE_MAIN) |=> o_reg_rdata[6])
        else $error("line bus wake flag not set");
    AST_OVL_HELD: assert property (
        rd_of(wss_pkg::ADDR_OVERLOAD) and ovl_seen |=> o_reg_rdata[0])
        else $error("overload flag lost");
    AST_OVL_CLEARED: assert property (
        rd_of(wss_pkg::ADDR_OVERLOAD) and !ovl_seen |=> !o_reg_rdata[0])
        else $error("overload flag not cleared");
    AST_STRAP_LIVE: assert property (
        (!i_srst && $stable(i_fail_out_test_pin))[*4] ##0
        rd_of(wss_pkg::ADDR_LEVEL) |=> o_reg_rdata[7] == $past(i_fail_out_test_pin))
        else $error("strap level wrong");
    COV_LEVEL: cover property (rd_of(wss_pkg::ADDR_LEVEL));
    COV_CLEAR: cover property (i_reg_clr && i_reg_addr == wss_pkg::ADDR_OVERLOAD);
    COV_OVL: cover property (rd_of(wss_pkg::ADDR_OVERLOAD) and ovl_seen);
endmodule
bind wss_status_regs wss_status_regs_assertions #(.NUM_HS(NUM_HS))
    wss_status_regs_assertions_inst (
    .i_clk(i_clk), .i_srst(i_srst), .i_lin_wake_evt(i_lin_wake_evt),
    .i_can_wake_evt(i_can_wake_evt), .i_hs_overload_evt(i_hs_overload_evt),
    .i_fail_out_test_pin(i_fail_out_test_pin), .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd),
    .i_reg_clr(i_reg_clr), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid));

// [dv/wss_host_model.sv]
// Host model that issues register reads and clear commands to the bank.
`timescale 1ns/100ps
module wss_host_model (
    // Clock and answer from the bank.
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rvalid,
    // Requests to the bank.
    output logic [6:0]      o_addr,
    output logic            o_rd,
    output logic            o_clr
);
    initial {o_addr, o_rd, o_clr} = '0;
    // One-cycle read strobe; the answer stands one cycle after the strobe edge.
    task automatic read_reg(input logic [6:0] a, output logic [7:0] d, output logic v);
        @(posedge i_clk);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_clk);
        o_rd   <= 1'b0;
        o_addr <= ~a; // A released address never keeps its old value.
        #1;
        d = i_rdata;
        v = i_rvalid;
    endtask
    // One-cycle clear command to one address.
    task automatic clear_reg(input logic [6:0] a);
        @(posedge i_clk);
        o_addr <= a;
        o_clr  <= 1'b1;
        @(posedge i_clk);
        o_clr  <= 1'b0;
        o_addr <= ~a;
    endtask
endmodule

// [dv/wss_status_regs_bench.sv]
// Self-checking bench of the wake and switch status bank.
`timescale 1ns/100ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin errors++; \
    $display("wrong value %s exp %h got %h", n, e, s); end end
module wss_status_regs_bench;
    int          errors = 0;     // Mismatches seen.
    int          checks = 0;     // Comparisons made.
    logic [31:0] seed, r;        // Xorshift state and draw.
    logic        i_clk, i_srst;  // Clock and reset.
    logic [15:0] ev, flags;      // Events and expected flags: lin,can,timer,wk,gp,ovl,open.
    logic        nos, cya, cys;  // Operating state and cyclic controls.
    logic        strap, pull;    // Strap and pull-up pins.
    logic [1:0]  sel, cfg, gp, eg; // Pin selects, levels and expected held level.
    logic [2:0]  wk, ew;         // Wake input levels and expected held level.
    logic [6:0]  addr;           // Host request lines.
    logic        rd, clr, rvalid;
    logic [7:0]  rdata, d;
    logic [6:0]  al [5] = '{wss_pkg::ADDR_WAKE_MAIN, wss_pkg::ADDR_WAKE_GP,
                            wss_pkg::ADDR_OVERLOAD, wss_pkg::ADDR_OPEN_LOAD, 7'h7f};
    wss_status_regs wss_status_regs_inst (
        .i_clk(i_clk), .i_srst(i_srst), .i_lin_wake_evt(ev[0]), .i_can_wake_evt(ev[1]),
        .i_timer_wake_evt(ev[2]), .i_wk_wake_evt(ev[5:3]), .i_gp_wake_evt(ev[7:6]),
        .i_hs_overload_evt(ev[11:8]), .i_hs_open_load_evt(ev[15:12]),
        .i_normal_or_stop(nos), .i_cyclic_active(cya), .i_cyclic_sample(cys),
        .i_gp_sel_gpio(sel), .i_gp_cfg_active(cfg), .i_wk_pin(wk), .i_gp_pin(gp),
        .i_fail_out_test_pin(strap), .i_int_pullup_pin(pull), .i_reg_addr(addr),
        .i_reg_rd(rd), .i_reg_clr(clr), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid));
    wss_host_model wss_host_model_inst (.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid),
        .o_addr(addr), .o_rd(rd), .o_clr(clr));
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Expected byte of a flag register, built from the flag model.
    function automatic logic [7:0] exp_reg(input logic [6:0] a);
        case (a)
            wss_pkg::ADDR_WAKE_MAIN: return {1'b0, flags[0], flags[1], flags[2], 1'b0, flags[5:3]};
            wss_pkg::ADDR_WAKE_GP:   return {2'b00, flags[7:6], 4'h0};
            wss_pkg::ADDR_OVERLOAD:  return {4'h0, flags[11:8]};
            wss_pkg::ADDR_OPEN_LOAD: return {4'h0, flags[15:12]};
            default:                 return 8'h00;
        endcase
    endfunction
    // Flags that a clear command to an address drops; other addresses drop none.
    function automatic logic [15:0] clr_mask(input logic [6:0] a);
        case (a)
            wss_pkg::ADDR_WAKE_MAIN: return 16'h003f;
            wss_pkg::ADDR_WAKE_GP:   return 16'h00c0;
            wss_pkg::ADDR_OVERLOAD:  return 16'h0f00;
            wss_pkg::ADDR_OPEN_LOAD: return 16'hf000;
            default:                 return 16'h0000;
        endcase
    endfunction
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
        logic v;
        wss_host_model_inst.read_reg(a, d, v);
        `CHK("rvalid", 1'b1, v)
        `CHK("rdata", e, d)
    endtask
    task automatic check_all();
        foreach (al[k]) rd_chk(al[k], exp_reg(al[k]));
    endtask
    task automatic clear_one(input logic [6:0] a);
        wss_host_model_inst.clear_reg(a);
        flags &= ~clr_mask(a);
    endtask
    task automatic pulse(input logic [15:0] v);
        @(posedge i_clk);
        ev <= v;
        @(posedge i_clk);
        ev <= '0;
        flags |= v;
    endtask
    task automatic lvl_chk();
        rd_chk(wss_pkg::ADDR_LEVEL, {strap, pull, eg, 1'b0, ew});
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////////
    // Watchdog: the whole sequence needs a few thousand cycles at most.
    initial begin
        repeat (20000) @(posedge i_clk);
        errors++;
        tally_and_finish();
    end
    initial begin
        {ev, flags, nos, cya, cys, strap, pull, sel, cfg, gp, wk, eg, ew} = '0;
        i_srst = 1'b1;
        seed   = 32'hf5b7b281;
        repeat (10) @(posedge i_clk);
        i_srst <= 1'b0;
        check_all();
        lvl_chk();
        // Each source alone, then random mixes; refused clears must change nothing.
        for (int i = 0; i < 28; i++) begin
            r = rnd();
            pulse(i < 16 ? 16'h0001 << i : r[15:0]);
            repeat (6) @(posedge i_clk);
            clear_one(wss_pkg::ADDR_LEVEL);
            clear_one(7'h7f);
            check_all();
            foreach (al[k]) clear_one(al[k]);
            check_all();
        end
        // An event in the cycle of its clear must survive.
        fork
            wss_host_model_inst.clear_reg(wss_pkg::ADDR_OVERLOAD);
            pulse(16'h0100);
        join
        check_all();
        clear_one(wss_pkg::ADDR_OVERLOAD);
        // Bus wakes read back in the very next cycle after their event.
        fork
            pulse(16'h0003);
            begin
                @(posedge i_clk);
                rd_chk(wss_pkg::ADDR_WAKE_MAIN, 8'h60);
            end
        join
        clear_one(wss_pkg::ADDR_WAKE_MAIN);
        // Random pin levels, states and selects.
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            @(posedge i_clk);
            {wk, gp, strap, pull, nos, sel, cfg} <= r[11:0];
            repeat (4) @(posedge i_clk);
            ew = wk;
            for (int g = 0; g < 2; g++) if (nos && (sel[g] || cfg[g])) eg[g] = gp[g];
            lvl_chk();
        end
        // Cyclic mode: wake levels move only at a sample, pin levels never do.
        @(posedge i_clk);
        cya <= 1'b1;
        nos <= 1'b0;
        wk  <= ~wk;
        gp  <= ~gp;
        repeat (4) @(posedge i_clk);
        lvl_chk();
        @(posedge i_clk);
        cys <= 1'b1;
        @(posedge i_clk);
        cys <= 1'b0;
        ew  = wk;
        lvl_chk();
        // A reset in mid-run wipes every flag.
        pulse(16'hffff);
        @(posedge i_clk);
        i_srst <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_srst <= 1'b0;
        flags = '0;
        check_all();
        tally_and_finish();
    end
endmodule
